// ### design/msgq_pkg.sv
/*
 package for the remote message and status block: register fields,
 capacities, reset values and the carrier structs.
 assumes a parser upstream that classifies header tokens and events.
*/
// Functional notes
// - keep common header path for following commands
// - clear path on power, key reset, colon, terminator
// - starred commands ignore and keep the path
// - queue holds responses; flush on power, clear, error
// - queue holds 64 bytes; overflow flags query error
// - bus message with unread output flushes, query error
// - input buffer 256 bytes; full stalls bus handshake
// - masked status bit rising sets summary, requests service
// - serial poll returns status byte, clears request
// - summary bit cleared only by clear-status or key reset
// - serial port raises no service request
// - status byte bit layout fixed
// - bit 5 is masked standard event summary
// - event flags cleared by clear, query, power-up
// - power-on flag bit 7; bits 6 and 1 unused
// - command error sets bit 5, skip to terminator
// - execution error sets bit 4
// - device error sets bit 3
// - query error sets bit 2 and flushes queue
// - operation complete sets bit 0 after prior messages
// - accept LF, CR+LF, end-or-identify terminators
// - event enable bit gates summary contribution
package msgq_pkg;
	localparam int OUT_DEPTH = 64;
	localparam int IN_DEPTH = 256;
	localparam int PATH_W = 16;
	localparam int STB_DEVICE_EVENT0_SUMMARY = 0;
	localparam int STB_DEVICE_EVENT1_SUMMARY = 1;
	localparam int STB_MAV = 4;
	localparam int STB_ESB = 5;
	localparam int STB_MSS = 6;
	localparam int EV_OPC = 0;
	localparam int EV_QYE = 2;
	localparam int EV_DDE = 3;
	localparam int EV_EXE = 4;
	localparam int EV_CME = 5;
	localparam int EV_PON = 7;
	localparam logic [7:0] EV_USED = 8'hbd;
	localparam logic [7:0] STB_USED = 8'h33;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] ASCII_LF = 8'h0a;
	localparam logic [7:0] ASCII_CR = 8'h0d;

	// one header token from the parser
	typedef struct packed {
		logic valid;
		logic leading_colon;
		logic starred;
		logic is_last;
		logic [PATH_W-1:0] node;
	} header_tok_t;

	// events reported by the command executor
	typedef struct packed {
		logic cmd_err;
		logic exe_err;
		logic dev_err;
		logic opc_done;
	} exec_ev_t;
endpackage

// ### design/byte_fifo.sv
/*
 fifo with valid/ready on both sides and a synchronous flush.
 assumes a single clock; flush wins over push and pop.
*/
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH+1)-1:0] count
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ff, rd_ff;
	logic [$clog2(DEPTH+1)-1:0] cnt_ff;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = (cnt_ff != DEPTH[$clog2(DEPTH+1)-1:0]);
	assign out_valid = (cnt_ff != '0);
	assign out_data = mem[rd_ff];
	assign count = cnt_ff;

	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ff] <= in_data;
	end

	// in-order delivery
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else if (flush) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push)
				wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
			if (pop)
				rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
			cnt_ff <= cnt_ff + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
		end
	end
endmodule
`default_nettype wire

// ### design/remote_status_and_message_queues.sv
/*
 remote message handling: header path, output queue, input buffer,
 status byte and standard event register.
 assumes a parser and executor around it; resetn is the power-on
 reset, key_reset the panel reset.
*/
`timescale 1ns/100ps
`default_nettype none
module remote_status_and_message_queues #(
	parameter int OUT_DEPTH = msgq_pkg::OUT_DEPTH,
	parameter int IN_DEPTH = msgq_pkg::IN_DEPTH,
	parameter int STAGE_DEPTH = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic key_reset,
	input wire logic serial_mode,
	// incoming bus bytes
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_eoi,
	output logic rx_ready,
	// bytes to the parser
	output logic cmd_valid,
	output logic [7:0] cmd_data,
	output logic cmd_term,
	input wire logic cmd_ready,
	input wire logic device_clear,
	// header tokens and resolved path
	input wire msgq_pkg::header_tok_t hdr_tok,
	output logic [msgq_pkg::PATH_W-1:0] path,
	output logic path_valid,
	// responses
	input wire logic resp_valid,
	input wire logic [7:0] resp_data,
	output logic resp_ready,
	input wire logic tx_read,
	output logic tx_valid,
	output logic [7:0] tx_data,
	// executor events and commands
	input wire msgq_pkg::exec_ev_t exec_ev,
	input wire logic opc_cmd,
	input wire logic pending_busy,
	input wire logic cls_cmd,
	input wire logic esr_query,
	input wire logic [7:0] ev_mask_wdata,
	input wire logic ev_mask_we,
	input wire logic [7:0] srq_mask_wdata,
	input wire logic srq_mask_we,
	input wire logic dev_event0,
	input wire logic dev_event1,
	input wire logic serial_poll,
	output logic discard_to_term,
	output logic [7:0] service_summary_byte,
	output logic [7:0] standard_event_flags,
	output logic [7:0] standard_event_mask,
	output logic [7:0] service_request_mask,
	output logic [7:0] poll_byte,
	output logic srq
);
	localparam int OCW = $clog2(OUT_DEPTH+1);
	localparam int ICW = $clog2(IN_DEPTH+1);

	// input buffer: 256 bytes, bytes and terminator flag together
	logic [8:0] in_mem [IN_DEPTH];
	logic [ICW-2:0] in_wr_ff, in_rd_ff;
	logic [ICW-1:0] in_cnt_ff;
	logic prev_cr_ff;
	wire in_full = (in_cnt_ff == ICW'(IN_DEPTH));
	wire byte_is_lf = (rx_data == msgq_pkg::ASCII_LF);
	wire term_mark = byte_is_lf || rx_eoi;
	// every cr without eoi is dropped, not only one before lf, so cr+lf is one terminator
	wire drop_cr = (rx_data == msgq_pkg::ASCII_CR) && !rx_eoi;
	wire flush_all = key_reset || device_clear;
	wire in_push = rx_valid && rx_ready && !drop_cr;
	wire in_pop = cmd_valid && cmd_ready;
	wire [8:0] in_head = in_mem[in_rd_ff];

	// full input buffer holds the handshake in wait
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			rx_ready <= 1'b0;
		else
			rx_ready <= !flush_all && (in_cnt_ff < ICW'(IN_DEPTH - 1)
				|| (in_cnt_ff == ICW'(IN_DEPTH - 1) && !in_push));
	end

	always_ff @(posedge clk) begin
		if (in_push)
			in_mem[in_wr_ff] <= {term_mark, rx_data};
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			in_wr_ff <= '0;
			in_rd_ff <= '0;
			in_cnt_ff <= '0;
			prev_cr_ff <= 1'b0;
		end else if (flush_all) begin
			in_wr_ff <= '0;
			in_rd_ff <= '0;
			in_cnt_ff <= '0;
			prev_cr_ff <= 1'b0;
		end else begin
			if (in_push && !in_full)
				in_wr_ff <= in_wr_ff + 1'b1;
			if (in_pop)
				in_rd_ff <= in_rd_ff + 1'b1;
			in_cnt_ff <= in_cnt_ff + ((in_push && !in_full) ? 1'b1 : 1'b0)
				- (in_pop ? 1'b1 : 1'b0);
			if (rx_valid && rx_ready)
				prev_cr_ff <= drop_cr;
		end
	end

	// registered parser face; a pop retires the shown byte
	logic cmd_valid_ff;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cmd_valid_ff <= 1'b0;
			cmd_data <= 8'h00;
			cmd_term <= 1'b0;
		end else begin
			cmd_valid_ff <= !flush_all && (in_cnt_ff > ICW'(in_pop ? 1 : 0));
			cmd_data <= in_pop ? in_mem[in_rd_ff + 1'b1][7:0] : in_head[7:0];
			cmd_term <= in_pop ? in_mem[in_rd_ff + 1'b1][8] : in_head[8];
		end
	end
	assign cmd_valid = cmd_valid_ff;

	wire msg_start = in_pop; // every byte the parser pops, not only a message's first
	logic term_seen;
	assign term_seen = in_pop && cmd_term;

	// header path
	logic [msgq_pkg::PATH_W-1:0] path_ff;
	logic [msgq_pkg::PATH_W-1:0] resolved_ff;
	logic resolved_v_ff;
	wire path_clear = key_reset || term_seen;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			path_ff <= '0;
			resolved_ff <= '0;
			resolved_v_ff <= 1'b0;
		end else begin
			resolved_v_ff <= hdr_tok.valid;
			if (hdr_tok.valid) begin
				if (hdr_tok.starred)
					resolved_ff <= hdr_tok.node;
				else if (hdr_tok.leading_colon)
					resolved_ff <= hdr_tok.node;
				else
					resolved_ff <= path_ff ^ hdr_tok.node;
			end
			// a colon restarts from the root even for a one-node header
			if (path_clear)
				path_ff <= '0;
			else if (hdr_tok.valid && !hdr_tok.starred
				&& hdr_tok.leading_colon)
				path_ff <= hdr_tok.is_last ? '0 : hdr_tok.node;
			else if (hdr_tok.valid && !hdr_tok.starred && !hdr_tok.is_last)
				path_ff <= path_ff ^ hdr_tok.node;
		end
	end
	assign path = resolved_ff;
	assign path_valid = resolved_v_ff;

	// response staging fifo feeding the output queue
	logic st_valid, st_ready;
	logic [7:0] st_data;
	logic q_flush;
	byte_fifo #(.WIDTH(8), .DEPTH(STAGE_DEPTH)) u_stage (
		.clk(clk),
		.resetn(resetn),
		.flush(q_flush),
		.in_valid(resp_valid),
		.in_ready(resp_ready),
		.in_data(resp_data),
		.out_valid(st_valid),
		.out_ready(st_ready),
		.out_data(st_data),
		.count()
	);

	// output queue, 64 bytes
	logic [7:0] oq_mem [OUT_DEPTH];
	logic [OCW-2:0] oq_wr_ff, oq_rd_ff;
	logic [OCW-1:0] oq_cnt_ff;
	wire oq_full = (oq_cnt_ff == OCW'(OUT_DEPTH));
	wire oq_empty = (oq_cnt_ff == '0);
	assign st_ready = 1'b1;
	wire overflow = st_valid && oq_full;
	wire empty_read = tx_read && oq_empty && !serial_mode;
	wire unread_hit = msg_start && !oq_empty && !serial_mode;
	wire query_err = overflow || empty_read || unread_hit;
	assign q_flush = flush_all || query_err;
	wire oq_push = st_valid && !oq_full;
	wire oq_pop = tx_read && !oq_empty;

	always_ff @(posedge clk) begin
		if (oq_push)
			oq_mem[oq_wr_ff] <= st_data;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			oq_wr_ff <= '0;
			oq_rd_ff <= '0;
			oq_cnt_ff <= '0;
		end else if (q_flush) begin
			oq_wr_ff <= '0;
			oq_rd_ff <= '0;
			oq_cnt_ff <= '0;
		end else begin
			if (oq_push)
				oq_wr_ff <= oq_wr_ff + 1'b1;
			if (oq_pop)
				oq_rd_ff <= oq_rd_ff + 1'b1;
			oq_cnt_ff <= oq_cnt_ff + (oq_push ? 1'b1 : 1'b0)
				- (oq_pop ? 1'b1 : 1'b0);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
		end else begin
			tx_valid <= !oq_empty && !q_flush && !(oq_pop && oq_cnt_ff == 1);
			tx_data <= oq_pop ? oq_mem[oq_rd_ff + 1'b1] : oq_mem[oq_rd_ff];
		end
	end

	// command error discards up to the terminator
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			discard_to_term <= 1'b0;
		else if (term_seen || flush_all)
			discard_to_term <= 1'b0;
		else if (exec_ev.cmd_err)
			discard_to_term <= 1'b1;
	end

	// operation complete waits for earlier messages
	logic opc_wait_ff;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			opc_wait_ff <= 1'b0;
		else if (flush_all)
			opc_wait_ff <= 1'b0;
		else if (opc_cmd)
			opc_wait_ff <= 1'b1;
		else if (!pending_busy)
			opc_wait_ff <= 1'b0;
	end
	wire opc_set = (opc_wait_ff && !pending_busy) || exec_ev.opc_done;

	// standard event flags; set wins over clear
	logic [7:0] ev_set;
	always_comb begin
		ev_set = 8'h00;
		ev_set[msgq_pkg::EV_CME] = exec_ev.cmd_err;
		ev_set[msgq_pkg::EV_EXE] = exec_ev.exe_err;
		ev_set[msgq_pkg::EV_DDE] = exec_ev.dev_err;
		ev_set[msgq_pkg::EV_QYE] = query_err;
		ev_set[msgq_pkg::EV_OPC] = opc_set;
	end
	wire ev_clear = cls_cmd || esr_query || key_reset;
	wire [7:0] nxt_ev = ((ev_clear ? 8'h00 : standard_event_flags) | ev_set)
		& msgq_pkg::EV_USED;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			standard_event_flags <= 8'h80; // power-on flag
		else
			standard_event_flags <= nxt_ev;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			standard_event_mask <= msgq_pkg::MASK_RESET;
			service_request_mask <= msgq_pkg::MASK_RESET;
		end else if (key_reset) begin
			standard_event_mask <= msgq_pkg::MASK_RESET;
			service_request_mask <= msgq_pkg::MASK_RESET;
		end else begin
			if (ev_mask_we)
				standard_event_mask <= ev_mask_wdata;
			if (srq_mask_we)
				service_request_mask <= srq_mask_wdata;
		end
	end

	// status byte assembly
	wire standard_event_summary = |(nxt_ev & standard_event_mask);
	logic [7:0] stb_low;
	always_comb begin
		stb_low = 8'h00;
		stb_low[msgq_pkg::STB_ESB] = standard_event_summary;
		stb_low[msgq_pkg::STB_MAV] = !oq_empty || oq_push;
		stb_low[msgq_pkg::STB_DEVICE_EVENT1_SUMMARY] = dev_event1;
		stb_low[msgq_pkg::STB_DEVICE_EVENT0_SUMMARY] = dev_event0;
	end
	logic [7:0] stb_prev_ff;
	wire [7:0] rising = stb_low & ~stb_prev_ff & service_request_mask
		& msgq_pkg::STB_USED;
	logic mss_ff;
	wire nxt_mss = !(cls_cmd || key_reset) && (mss_ff || (|rising)) ;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stb_prev_ff <= 8'h00;
			mss_ff <= 1'b0;
			srq <= 1'b0;
			service_summary_byte <= 8'h00;
			poll_byte <= 8'h00;
		end else begin
			stb_prev_ff <= stb_low;
			mss_ff <= nxt_mss || (|rising);
			service_summary_byte <= stb_low
				| ((nxt_mss || (|rising)) ? 8'h40 : 8'h00);
			if (|rising && !serial_mode)
				srq <= 1'b1;
			else if (serial_poll || serial_mode || cls_cmd)
				srq <= 1'b0;
			if (serial_poll)
				poll_byte <= stb_low | (srq ? 8'h40 : 8'h00);
		end
	end
endmodule
`default_nettype wire

// ### test/rsmq_monitor.sv
/*
 checker on the block's ports: service request, summary bits, flags.
 assumes it is bound into the block with the port names unchanged.
*/
`timescale 1ns/100ps
`default_nettype none
module rsmq_monitor (
	input wire logic clk,
	input wire logic resetn,
	input wire logic serial_mode,
	input wire logic serial_poll,
	input wire logic cls_cmd,
	input wire logic key_reset,
	input wire msgq_pkg::exec_ev_t exec_ev,
	input wire logic tx_valid,
	input wire logic srq,
	input wire logic [7:0] service_summary_byte,
	input wire logic [7:0] standard_event_flags,
	input wire logic [7:0] standard_event_mask,
	input wire logic [7:0] service_request_mask
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	wire [7:0] sb;
	wire masked;
	assign sb = service_summary_byte;
	// the summary bit itself is left out, or it would retrigger itself
	assign masked = |(sb & service_request_mask & 8'h3f);
	chk_srq_rise: assert property (
		$rose(masked) && $stable(service_request_mask) && !serial_mode
		&& !serial_poll |-> ##[1:3] srq)
		else $error("service request not raised");
	chk_serial_quiet: assert property (
		$rose(srq) |-> !serial_mode && !$past(serial_mode))
		else $error("service request on serial port");
	chk_poll_drop: assert property (serial_poll |=> !srq)
		else $error("poll left request set");
	chk_mss_keep: assert property (
		$fell(sb[6]) |-> $past(cls_cmd) || $past(cls_cmd, 2)
		|| $past(key_reset) || $past(key_reset, 2))
		else $error("summary bit dropped without clear");
	chk_esb_sum: assert property (
		|(standard_event_flags & standard_event_mask) && !cls_cmd
		&& !key_reset |-> ##[0:1] sb[5])
		else $error("event summary missing");
	chk_mav_bit: assert property (tx_valid |-> ##[0:1] sb[4])
		else $error("message waiting bit missing");
	chk_unused_zero: assert property (
		(sb & 8'h8c) == 8'h00 && (standard_event_flags & 8'h42) == 8'h00)
		else $error("unused bit set");
	chk_cmd_err: assert property (
		exec_ev.cmd_err |=> standard_event_flags[5])
		else $error("command error flag missing");
endmodule
`default_nettype wire

// ### test/host_ctrl.sv
/*
 host controller model: offers program message bytes on the input
 handshake. assumes its tasks are called just after a rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module host_ctrl (
	input wire logic clk,
	input wire logic rx_ready,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_eoi
);
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_eoi = 1'b0;
	end
	// released data shows its inverse so a late sample cannot pass
	task automatic idle();
		rx_valid = 1'b0;
		rx_data = ~rx_data;
		rx_eoi = 1'b0;
	endtask
	// eoi or a line feed ends the message
	task automatic send(input logic [7:0] d, input logic t, input int gap);
		if (gap > 0) begin
			idle();
			repeat (gap) @(posedge clk);
			#1;
		end
		rx_valid = 1'b1;
		rx_data = d;
		rx_eoi = t;
		@(negedge clk);
		while (rx_ready !== 1'b1)
			@(negedge clk);
		@(posedge clk);
		#1;
	endtask
endmodule
`default_nettype wire

// ### test/remote_status_and_message_queues_bench.sv
/*
 bench for the message block: host model feeds the input buffer,
 the bench drives responses, events and register writes.
 assumes package, design, monitor and host model compile first.
*/
`timescale 1ns/100ps
`default_nettype none
module remote_status_and_message_queues_bench;
	logic clk = '0, resetn = '0, key_reset = '0, serial_mode = '0;
	logic cmd_ready = '0, device_clear = '0, resp_valid = '0, stall = '1;
	logic tx_read = '0, opc_cmd = '0, pending_busy = '0, cls_cmd = '0;
	logic esr_query = '0, ev_mask_we = '0, srq_mask_we = '0;
	logic dev_event0 = '0, dev_event1 = '0, serial_poll = '0;
	logic [7:0] resp_data = '0, ev_mask_wdata = '0, srq_mask_wdata = '0;
	msgq_pkg::header_tok_t hdr_tok = '0;
	msgq_pkg::exec_ev_t exec_ev = '0;
	logic rx_valid, rx_eoi, rx_ready, cmd_valid, cmd_term, tx_valid;
	logic srq, path_valid, resp_ready, discard_to_term;
	logic [7:0] rx_data, cmd_data, tx_data, poll_byte, e, b;
	logic [7:0] service_summary_byte, service_request_mask;
	logic [7:0] standard_event_flags, standard_event_mask;
	logic [msgq_pkg::PATH_W-1:0] path;
	logic [8:0] cq[$];
	logic [7:0] rq[$];
	int fails = '0, tests_run = '0, cyc = '0, n = '0;
	int seed = 32'h89c9;

	always #10 clk = ~clk;
	host_ctrl host (.clk, .rx_ready, .rx_valid, .rx_data, .rx_eoi);
	remote_status_and_message_queues dut (.*);

	task automatic check(input string nm, input logic [16:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
		tick(1);
	endtask
	// a carriage return without eoi never reaches the parser
	task automatic put(input logic [7:0] d, input logic t);
		if (d != 8'h0d)
			cq.push_back({d == 8'h0a || t, d});
		host.send(d, t, $random(seed) & 1);
	endtask
	// one header token; the resolved path shows one edge later
	task automatic tok(input logic c, s, l, input logic [15:0] nd, exp);
		hdr_tok = {1'b1, c, s, l, nd};
		tick(1);
		hdr_tok = '0;
		check("pathv", path_valid, 1'b1);
		check("path", path, exp);
		tick(1);
	endtask
	task automatic respond(input int k);
		repeat (k) begin
			resp_valid = 1'b1;
			resp_data = $random(seed);
			rq.push_back(resp_data);
			@(negedge clk);
			while (resp_ready !== 1'b1)
				@(negedge clk);
			tick(1);
		end
		resp_valid = 1'b0;
	endtask

	always @(posedge clk) begin
		#1;
		cmd_ready = !stall && ($random(seed) & 1) != 0;
	end
	// sampled mid-cycle: outputs settled, pop happens at the next edge
	always @(negedge clk) begin
		cyc <= cyc + 1;
		if (cmd_valid && cmd_ready)
			check("cmd", {cmd_term, cmd_data},
				cq.size() > 0 ? cq.pop_front() : 9'h1ff);
		if (tx_read && tx_valid)
			check("tx", {1'b0, tx_data},
				rq.size() > 0 ? {1'b0, rq.pop_front()} : 9'h1ff);
		if (cyc == 8000) begin
			fails++;
			finish_test();
		end
	end

	initial begin
		tick(12);
		resetn = 1'b1;
		tick(1);
		check("flags", standard_event_flags, 8'h80);
		check("stb", service_summary_byte, 8'h00);
		pulse(esr_query);
		check("flags", standard_event_flags, 8'h00);
		e = 8'h00;
		for (int i = 0; i < 3; i++) begin
			exec_ev = 4'h8 >> i;
			e = e | (8'h20 >> i);
			tick(1);
			exec_ev = '0;
			tick(1);
			check("flags", standard_event_flags, e);
		end
		check("skip", discard_to_term, 1'b1);
		pending_busy = 1'b1;
		pulse(opc_cmd);
		tick(2);
		check("opc", standard_event_flags[0], 1'b0);
		pending_busy = 1'b0;
		tick(3);
		check("opc", standard_event_flags[0], 1'b1);
		ev_mask_wdata = 8'h01;
		srq_mask_wdata = 8'h20;
		ev_mask_we = 1'b1;
		pulse(srq_mask_we);
		ev_mask_we = 1'b0;
		tick(3);
		check("mask", service_request_mask, 8'h20);
		check("stb", service_summary_byte, 8'h60);
		check("srq", srq, 1'b1);
		pulse(serial_poll);
		check("srq", srq, 1'b0);
		check("poll", poll_byte, 8'h60);
		check("stb", service_summary_byte, 8'h60);
		pulse(cls_cmd);
		check("stb", service_summary_byte, 8'h00);
		stall = 1'b0;
		for (int i = 0; i < 40; i++) begin
			b = $random(seed);
			put(b | 8'h10, 1'b0);
		end
		put(8'h0d, 1'b0);
		put(8'h0a, 1'b0);
		put(8'h5a, 1'b1);
		host.idle();
		tick(60);
		check("left", cq.size() == 0, 1'b1);
		check("skip", discard_to_term, 1'b0);
		tok(1'b1, 1'b0, 1'b0, 16'h1200, 16'h1200);
		tok(1'b0, 1'b0, 1'b1, 16'h0034, 16'h1234);
		tok(1'b0, 1'b1, 1'b1, 16'h0abc, 16'h0abc);
		tok(1'b0, 1'b0, 1'b1, 16'h0056, 16'h1256);
		tok(1'b1, 1'b0, 1'b1, 16'h0078, 16'h0078);
		tok(1'b0, 1'b0, 1'b1, 16'h0034, 16'h0034);
		tok(1'b1, 1'b0, 1'b0, 16'h1200, 16'h1200);
		put(8'h0a, 1'b1);
		host.idle();
		tick(12);
		tok(1'b0, 1'b0, 1'b1, 16'h0034, 16'h0034);
		// the parser stalls, so the buffer must push back on the bus
		stall = 1'b1;
		tick(2);
		for (n = 0; n < 300 && rx_ready === 1'b1; n++)
			put(n[7:0] | 8'h10, 1'b0);
		check("fill", n >= 256 && n <= 257, 1'b1);
		stall = 1'b0;
		host.idle();
		tick(700);
		check("left", cq.size() == 0, 1'b1);
		respond(5);
		tick(8);
		check("mav", service_summary_byte[4], 1'b1);
		repeat (5) begin
			tx_read = 1'b1;
			tick(1);
			tx_read = 1'b0;
			tick(2);
		end
		check("read", rq.size() == 0, 1'b1);
		check("mav", service_summary_byte[4], 1'b0);
		pulse(tx_read);
		tick(1);
		check("qye", standard_event_flags[2], 1'b1);
		pulse(cls_cmd);
		respond(65);
		tick(40);
		check("qye", standard_event_flags[2], 1'b1);
		check("flush", tx_valid, 1'b0);
		rq.delete();
		pulse(cls_cmd);
		respond(2);
		tick(8);
		put(8'h0a, 1'b0);
		host.idle();
		tick(10);
		check("qye", standard_event_flags[2], 1'b1);
		check("flush", tx_valid, 1'b0);
		rq.delete();
		serial_mode = 1'b1;
		pulse(cls_cmd);
		pulse(tx_read);
		tick(2);
		check("serial", standard_event_flags[2], 1'b0);
		finish_test();
	end
endmodule
bind remote_status_and_message_queues rsmq_monitor mon (.clk, .resetn,
	.serial_mode, .serial_poll, .cls_cmd, .key_reset, .exec_ev, .tx_valid,
	.srq, .service_summary_byte, .standard_event_flags,
	.standard_event_mask, .service_request_mask);
`default_nettype wire
